// [rtl/pms_pkg.sv]
// pms_pkg: register map, field layout, reset values and timing for the
// power state and clock gating block.
// assumes a 200 MHz hclk and a 32-bit AHB-Lite register bus.
package pms_pkg;

    // register byte offsets
    localparam logic [11:0] PWR_CTRL_OFS  = 12'h084;
    localparam logic [11:0] HARDWARE_CONFIG_REGISTER_OFS    = 12'h074;
    localparam logic [11:0] BYTE_PROBE_OFS = 12'h064;

    // power control register fields
    localparam int SEL_HI       = 31;
    localparam int SEL_LO       = 29;
    localparam int SLEEP_REQ_B  = 28;
    localparam int AUTO_WAKE_B  = 27;
    localparam int IND_OFF_B    = 26;
    localparam int TIMING_OFF_B = 25;
    localparam int STAMP_OFF_B  = 22;
    localparam int MAC_OFF_B    = 19;
    localparam int MAC_SYS_OFF_B = 18;
    localparam int WAKE_LATE_B  = 1;
    localparam int READY_B      = 0;

    // hardware config register fields
    localparam int HW_READY_B   = 27;

    // byte order probe pattern, value is arbitrary
    localparam logic [31:0] BYTE_PROBE_VAL = 32'h1234_5678;

    // sleep level encodings
    localparam logic [2:0] LVL_D0 = 3'h0;
    localparam logic [2:0] LVL_D1 = 3'h1;
    localparam logic [2:0] LVL_D2 = 3'h2;
    localparam logic [2:0] LVL_D3 = 3'h3;

    // reset values
    localparam logic [2:0] SEL_RST   = 3'h0;
    localparam logic       BIT_RST   = 1'b0;
    // synchroniser reset: par_cs_n, par_wr_n, ser_cs_n idle high
    localparam logic [5:0] SYNC_RST  = 6'h07;

    // wake time limit
    localparam int CLK_MHZ      = 200;
    localparam int WAKE_MAX_NS  = 2_000_000;
    localparam int WAKE_MAX_CYC = WAKE_MAX_NS * CLK_MHZ / 1000;

    // chip level state, gray coded along run -> sleep -> wake; wake -> run flips both bits
    typedef enum logic [1:0]
    {
        PMS_RUN   = 2'b00,
        PMS_SLEEP = 2'b01,
        PMS_WAKE  = 2'b11
    } pms_state_e;

endpackage : pms_pkg

// [rtl/pms_arm_bit.sv]
// pms_arm_bit: a control bit that only sets after two consecutive writes
// of one; any write of zero clears it and the pending count.
// assumes wr_stb is a one-cycle pulse per register write.
module pms_arm_bit
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic wr_stb,
    input  wire logic wr_val,
    output logic      bit_q
);

    logic armed;

    ////////////////////////////////////////////////////////////////////////
    // first write of one arms, second sets; write of zero restarts
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            armed <= pms_pkg::BIT_RST;
            bit_q <= pms_pkg::BIT_RST;
        end
        else if (wr_stb)
        begin
            if (!wr_val)
            begin
                armed <= 1'b0;
                bit_q <= 1'b0;
            end
            else if (armed)
            begin
                bit_q <= 1'b1;
            end
            else
            begin
                armed <= 1'b1;
            end
        end
    end

endmodule : pms_arm_bit

// [rtl/pms_power_ctrl.sv]
// pms_power_ctrl: chip power states D0..D3, ready flag, wake handling and
// block clock gating, with registers on an AHB-Lite slave.
// assumes host port pins arrive asynchronously and hclk keeps running.
// Summary of operation
// - gating freezes blocks, never resets them
// - mac clock off needs two writes
// - mac system clock off needs two writes
// - timing unit clock off needs two writes
// - stamp unit clock off needs two writes
// - indicators off: tristate drains, idle push-pull
// - registers keep contents in every state; level and sleep request clear on ready
// - any reset enters full operation D0
// - sleep states stop all system clocks
// - D1 keeps oscillator and PLL running
// - D2 requests PLL off, needs PHY down
// - D3 stops everything, manual wake only
// - entering sleep forces ready flag low
// - host interface stalls while asleep
// - auto wake returns to D0 on event
// - parallel write wakes; writes ignored until a read
// - serial cycle wakes the device
// - ready rises after PLL lock, clearing sleep
// - level codes D0..D3, others reserved
// - level write ignored with sleep request
module pms_power_ctrl
#(
    parameter int          LED_N         = 3,
    parameter logic [2:0]  LED_DRAIN     = 3'h1,
    parameter logic [2:0]  LED_IDLE      = 3'h7,
    parameter int          WAKE_LIMIT    = pms_pkg::WAKE_MAX_CYC
)
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              par_cs_n,
    input  wire logic              par_wr_n,
    input  wire logic              ser_cs_n,
    input  wire logic              ser_clk,
    input  wire logic              pll_locked,
    input  wire logic              phy_powered_down,
    input  wire logic              wake_event,
    input  wire logic [LED_N-1:0]  led_drive,
    output logic [LED_N-1:0]       led_o,
    output logic [LED_N-1:0]       led_oe_n,
    output logic                   sys_clk_en,
    output logic                   pll_enable,
    output logic                   pll_off_request,
    output logic                   xtal_enable,
    output logic                   net_clk_en,
    output logic                   mac_sys_clk_en,
    output logic                   mac_net_clk_en,
    output logic                   timing_clk_en,
    output logic                   stamp_clk_en,
    output logic                   device_ready
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    pms_pkg::pms_state_e state;
    pms_pkg::pms_state_e next_state;
    logic [2:0]  sleep_state_select;
    logic [2:0]  level;
    logic        sleep_request;
    logic        auto_wake_enable;
    logic        indicator_outputs_off;
    logic        mac_clock_off;
    logic        mac_system_clock_off;
    logic        timing_unit_clock_off;
    logic        stamp_unit_clock_off;
    logic        wake_late;
    logic        wr_block;
    logic [19:0] wake_cnt;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  pins;
    logic [5:0]  pins_prev;
    logic        dp_act;
    logic        dp_write;
    logic [11:0] dp_addr;
    logic        ap_take;
    logic        wr_stb;
    logic        pwr_wr;
    logic        go_sleep;
    logic        manual_wake;
    logic        auto_wake;
    logic        asleep;

    // register offset match on a word address
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: address phase capture, stall while not in D0
    assign ap_take = hsel && htrans[1] && hready;
    assign hreadyout = !dp_act || (state == pms_pkg::PMS_RUN);
    assign hresp     = 1'b0;
    assign wr_stb    = dp_act && dp_write && hreadyout && !wr_block;
    assign pwr_wr    = wr_stb && hit(dp_addr, pms_pkg::PWR_CTRL_OFS);

    // data phase tracking
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_act   <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 12'h000;
        end
        else if (hreadyout)
        begin
            dp_act   <= ap_take;
            dp_write <= hwrite;
            dp_addr  <= haddr[11:0];
        end
    end

    // read data register, refreshed while a read is held
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if ((ap_take && hreadyout && !hwrite) || (dp_act && !dp_write))
        begin
            hrdata <= read_mux(hreadyout ? haddr[11:0] : dp_addr);
        end
    end

    // register read multiplexer, reserved bits read zero
    function automatic logic [31:0] read_mux(input logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (hit(a, pms_pkg::PWR_CTRL_OFS))
        begin
            r[pms_pkg::SEL_HI:pms_pkg::SEL_LO] = sleep_state_select;
            r[pms_pkg::SLEEP_REQ_B]   = sleep_request;
            r[pms_pkg::AUTO_WAKE_B]   = auto_wake_enable;
            r[pms_pkg::IND_OFF_B]     = indicator_outputs_off;
            r[pms_pkg::TIMING_OFF_B]  = timing_unit_clock_off;
            r[pms_pkg::STAMP_OFF_B]   = stamp_unit_clock_off;
            r[pms_pkg::MAC_OFF_B]     = mac_clock_off;
            r[pms_pkg::MAC_SYS_OFF_B] = mac_system_clock_off;
            r[pms_pkg::WAKE_LATE_B]   = wake_late;
            r[pms_pkg::READY_B]       = device_ready;
        end
        else if (hit(a, pms_pkg::HARDWARE_CONFIG_REGISTER_OFS))
        begin
            r[pms_pkg::HW_READY_B] = device_ready;
        end
        else if (hit(a, pms_pkg::BYTE_PROBE_OFS))
        begin
            r = pms_pkg::BYTE_PROBE_VAL;
        end
        read_mux = r;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////
    // double-write protected clock disables
    // mac clocks
    pms_arm_bit u_mac_off
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_stb  (pwr_wr),
        .wr_val  (hwdata[pms_pkg::MAC_OFF_B]),
        .bit_q   (mac_clock_off)
    );

    pms_arm_bit u_mac_sys_off
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_stb  (pwr_wr),
        .wr_val  (hwdata[pms_pkg::MAC_SYS_OFF_B]),
        .bit_q   (mac_system_clock_off)
    );

    pms_arm_bit u_timing_off
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_stb  (pwr_wr),
        .wr_val  (hwdata[pms_pkg::TIMING_OFF_B]),
        .bit_q   (timing_unit_clock_off)
    );

    pms_arm_bit u_stamp_off
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_stb  (pwr_wr),
        .wr_val  (hwdata[pms_pkg::STAMP_OFF_B]),
        .bit_q   (stamp_unit_clock_off)
    );

    ////////////////////////////////////////////////////////////////////////
    // plain control bits; contents survive every power state
    // no clear on sleep
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            auto_wake_enable      <= pms_pkg::BIT_RST;
            indicator_outputs_off <= pms_pkg::BIT_RST;
        end
        else if (pwr_wr)
        begin
            auto_wake_enable      <= hwdata[pms_pkg::AUTO_WAKE_B];
            indicator_outputs_off <= hwdata[pms_pkg::IND_OFF_B];
        end
    end

    // sleep request taken only with an unchanged level field
    assign go_sleep = pwr_wr && hwdata[pms_pkg::SLEEP_REQ_B]
                      && (hwdata[pms_pkg::SEL_HI:pms_pkg::SEL_LO] == sleep_state_select);

    // level field and sleep request, both cleared when ready returns
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sleep_state_select <= pms_pkg::SEL_RST;
            sleep_request      <= pms_pkg::BIT_RST;
        end
        else if (state == pms_pkg::PMS_WAKE && next_state == pms_pkg::PMS_RUN)
        begin
            sleep_state_select <= pms_pkg::SEL_RST;
            sleep_request      <= 1'b0;
        end
        else if (pwr_wr)
        begin
            if (!hwdata[pms_pkg::SLEEP_REQ_B])
            begin
                sleep_state_select <= hwdata[pms_pkg::SEL_HI:pms_pkg::SEL_LO];
            end
            if (go_sleep)
            begin
                sleep_request <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1     <= pms_pkg::SYNC_RST;
            sync2     <= pms_pkg::SYNC_RST;
            sync3     <= pms_pkg::SYNC_RST;
            pins      <= pms_pkg::SYNC_RST;
            pins_prev <= pms_pkg::SYNC_RST;
        end
        else
        begin
            sync1     <= {phy_powered_down, pll_locked, ser_clk, ser_cs_n, par_wr_n, par_cs_n};
            sync2     <= sync1;
            sync3     <= sync2;
            pins      <= (sync2 & sync3) | (pins & (sync2 ^ sync3));
            pins_prev <= pins;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake sources
    assign asleep = (state == pms_pkg::PMS_SLEEP);
    assign manual_wake = asleep && (((!pins[0] && !pins[1]) && !(!pins_prev[0] && !pins_prev[1]))
                                    || (!pins[2] && pins[3]));
    assign auto_wake = asleep && auto_wake_enable && wake_event && (level != pms_pkg::LVL_D3);

    assign level = (sleep_state_select > pms_pkg::LVL_D3) ? pms_pkg::LVL_D1 : sleep_state_select;

    ////////////////////////////////////////////////////////////////////////
    // chip level state machine
    always_comb
    begin
        next_state = state;
        case (state)
            pms_pkg::PMS_RUN:
            begin
                if (go_sleep)
                begin
                    next_state = (sleep_state_select == pms_pkg::LVL_D0) ? pms_pkg::PMS_WAKE
                                                                          : pms_pkg::PMS_SLEEP;
                end
            end
            pms_pkg::PMS_SLEEP:
            begin
                if (manual_wake || auto_wake)
                begin
                    next_state = pms_pkg::PMS_WAKE;
                end
            end
            pms_pkg::PMS_WAKE:
            begin
                if (pins[4])
                begin
                    next_state = pms_pkg::PMS_RUN;
                end
            end
            default:
            begin
                next_state = pms_pkg::PMS_WAKE;
            end
        endcase
    end

    // reset enters D0 via lock wait
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= pms_pkg::PMS_WAKE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ready flag, shown in both registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            device_ready <= 1'b0;
        end
        else if (next_state != pms_pkg::PMS_RUN)
        begin
            device_ready <= 1'b0;
        end
        else
        begin
            device_ready <= 1'b1;
        end
    end

    // writes ignored after a wake until a read completes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_block <= 1'b0;
        end
        else if (asleep && next_state == pms_pkg::PMS_WAKE)
        begin
            wr_block <= 1'b1;
        end
        else if (dp_act && !dp_write && hreadyout)
        begin
            wr_block <= 1'b0;
        end
    end

    // wake time watchdog, flags a wake slower than the limit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_cnt  <= 20'h00000;
            wake_late <= 1'b0;
        end
        else if (state != pms_pkg::PMS_WAKE)
        begin
            wake_cnt <= 20'h00000;
            if (go_sleep)
            begin
                wake_late <= 1'b0;
            end
        end
        else if (wake_cnt >= WAKE_LIMIT[19:0])
        begin
            wake_late <= 1'b1;
        end
        else
        begin
            wake_cnt <= wake_cnt + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source controls per state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sys_clk_en      <= 1'b0;
            pll_enable      <= 1'b1;
            pll_off_request <= 1'b0;
            xtal_enable     <= 1'b1;
            net_clk_en      <= 1'b1;
        end
        else
        begin
            sys_clk_en      <= (next_state == pms_pkg::PMS_RUN);
            // D2 PLL off with PHY down
            pll_off_request <= (next_state == pms_pkg::PMS_SLEEP) && (level >= pms_pkg::LVL_D2);
            pll_enable      <= !((next_state == pms_pkg::PMS_SLEEP) && ((level == pms_pkg::LVL_D3)
                                 || (level == pms_pkg::LVL_D2 && pins[5])));
            xtal_enable     <= !((next_state == pms_pkg::PMS_SLEEP) && (level == pms_pkg::LVL_D3));
            net_clk_en      <= !((next_state == pms_pkg::PMS_SLEEP) && (level == pms_pkg::LVL_D3));
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mac_sys_clk_en <= 1'b0;
            mac_net_clk_en <= 1'b1;
            timing_clk_en  <= 1'b0;
            stamp_clk_en   <= 1'b0;
        end
        else
        begin
            mac_sys_clk_en <= (next_state == pms_pkg::PMS_RUN) && !mac_clock_off && !mac_system_clock_off;
            mac_net_clk_en <= !((next_state == pms_pkg::PMS_SLEEP) && (level == pms_pkg::LVL_D3))
                              && !mac_clock_off;
            timing_clk_en  <= (next_state == pms_pkg::PMS_RUN) && !timing_unit_clock_off;
            stamp_clk_en   <= (next_state == pms_pkg::PMS_RUN) && !timing_unit_clock_off
                              && !stamp_unit_clock_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator pins: drain types drive only the active level
    // tristate or idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            led_o    <= LED_IDLE[LED_N-1:0];
            led_oe_n <= LED_DRAIN[LED_N-1:0];
        end
        else
        begin
            for (int i = 0; i < LED_N; i++)
            begin
                if (LED_DRAIN[i])
                begin
                    led_o[i]    <= ~LED_IDLE[i];
                    led_oe_n[i] <= indicator_outputs_off || (led_drive[i] == LED_IDLE[i]);
                end
                else
                begin
                    led_o[i]    <= indicator_outputs_off ? LED_IDLE[i] : led_drive[i];
                    led_oe_n[i] <= 1'b0;
                end
            end
        end
    end

endmodule : pms_power_ctrl

// [verif/pms_chk.sv]
// pms_chk: port assertions for pms_power_ctrl.
// assumes one slave on the bus, so hready is this slave's hreadyout.
module pms_chk
#(
    parameter int         LED_N     = 3,
    parameter logic [2:0] LED_DRAIN = 3'h1
)
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             pll_locked,
    input wire logic [LED_N-1:0] led_oe_n,
    input wire logic             sys_clk_en,
    input wire logic             pll_enable,
    input wire logic             pll_off_request,
    input wire logic             xtal_enable,
    input wire logic             net_clk_en,
    input wire logic             mac_sys_clk_en,
    input wire logic             mac_net_clk_en,
    input wire logic             device_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dphase;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////
    // data phase of a transfer taken by this slave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dphase <= 1'b0;
        else if (hready)
            dphase <= hsel && htrans[1];
    end
    // ready rising edge; a_ready_lock checks that the pll had locked the cycle before
    sequence s_up;
        $rose(device_ready);
    endsequence
    a_sleep_not_ready: assert property (!sys_clk_en |-> !device_ready) else $error("ready high in sleep");
    a_run_clocks: assert property (sys_clk_en |-> pll_enable && xtal_enable) else $error("run without pll");
    a_xtal_off_all: assert property (!xtal_enable |-> !pll_enable && !net_clk_en) else $error("d3 clocks on");
    a_pll_off_req: assert property (!pll_enable |-> pll_off_request || !xtal_enable) else $error("pll off");
    a_bus_stall: assert property (dphase && !sys_clk_en |-> !hreadyout) else $error("bus done asleep");
    a_mac_off_all: assert property (!mac_net_clk_en |-> !mac_sys_clk_en) else $error("mac gate");
    a_led_push: assert property ((led_oe_n & ~LED_DRAIN) == '0) else $error("push-pull released");
    a_reset_ready: assert property ($rose(hresetn) |-> ##[1:100] device_ready) else $error("no d0");
    a_ready_lock: assert property (s_up |-> sys_clk_en && $past(pll_locked)) else $error("ready early");
endmodule : pms_chk

bind pms_power_ctrl pms_chk #(.LED_N(LED_N), .LED_DRAIN(LED_DRAIN)) pms_chk_i (.hclk, .hresetn, .hsel,
    .htrans, .hready, .hreadyout, .pll_locked, .led_oe_n, .sys_clk_en, .pll_enable, .pll_off_request,
    .xtal_enable, .net_clk_en, .mac_sys_clk_en, .mac_net_clk_en, .device_ready);

// [verif/pms_pll_model.sv]
// pms_pll_model: pll lock as seen by the power controller.
// assumes hclk runs in every state.
module pms_pll_model
#(
    parameter int LOCK_CYC = 8
)
(
    input  wire logic hclk,
    input  wire logic pll_enable,
    input  wire logic xtal_enable,
    output logic      pll_locked = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // lock needs oscillator and pll on for a while, drops at once
    always @(posedge hclk)
    begin
        if (!(pll_enable && xtal_enable))
            cnt <= 0;
        else if (cnt < LOCK_CYC)
            cnt <= cnt + 1;
        pll_locked <= pll_enable && xtal_enable && cnt >= LOCK_CYC;
    end
endmodule : pms_pll_model

// [verif/pms_power_ctrl_tb.sv]
// pms_power_ctrl_tb: register and power state tests over AHB-Lite.
// assumes the pll model relocks well inside the wake limit.
module pms_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PC  = {20'h0, pms_pkg::PWR_CTRL_OFS};
    localparam logic [31:0] RDY = 32'h1 << pms_pkg::READY_B;
    localparam logic [31:0] SLP = 32'h1 << pms_pkg::SLEEP_REQ_B;
    localparam logic [31:0] AW  = 32'h1 << pms_pkg::AUTO_WAKE_B;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdata;
    logic [1:0] htrans = '0;
    logic par_cs_n = 1, par_wr_n = 1, ser_cs_n = 1, ser_clk = 0, phy_powered_down = 0, wake_event = 0;
    logic [2:0] led_o, led_oe_n;
    logic hreadyout, hresp, pll_locked, sys_clk_en, pll_enable, pll_off_request, xtal_enable, net_clk_en;
    logic mac_sys_clk_en, mac_net_clk_en, timing_clk_en, stamp_clk_en, device_ready;
    int err_count = 0;
    int comparisons = 0;
    int gate[4] = '{pms_pkg::MAC_OFF_B, pms_pkg::MAC_SYS_OFF_B, pms_pkg::TIMING_OFF_B, pms_pkg::STAMP_OFF_B};
    logic [3:0] ens[4] = '{4'h3, 4'hb, 4'hd, 4'he};
    logic [3:0] msk[4] = '{4'hf, 4'hf, 4'h2, 4'h1};
    ////////////////////////////////////////////////////////////////////////////
    pms_power_ctrl #(.WAKE_LIMIT(50)) pms_power_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .par_cs_n, .par_wr_n,
        .ser_cs_n, .ser_clk, .pll_locked, .phy_powered_down, .wake_event, .led_drive(3'h4), .led_o,
        .led_oe_n, .sys_clk_en, .pll_enable, .pll_off_request, .xtal_enable, .net_clk_en, .mac_sys_clk_en,
        .mac_net_clk_en, .timing_clk_en, .stamp_clk_en, .device_ready);
    pms_pll_model pms_pll_model_i (.hclk, .pll_enable, .xtal_enable, .pll_locked);
    // 200 MHz clock
    always #2.5 hclk = ~hclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk
    // wait for hready high at a rising edge, keeping the settled read data
    task wait_bus;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rdata = hrdata;
        @(posedge hclk);
    endtask : wait_bus
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_bus;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_bus;
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rchk(input logic [31:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp, m);
    endtask : rchk
    task wait_up;
        @(negedge hclk);
        repeat (400) if (device_ready !== 1'b1) @(negedge hclk);
        chk(device_ready, 1'b1, "ready");
    endtask : wait_up
    // level first, sleep request in a later write
    task sleep_in(input logic [31:0] cfg);
        wr(PC, cfg);
        wr(PC, cfg | SLP);
        repeat (4) @(posedge hclk);
    endtask : sleep_in
    task summarize;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        wait_up;
        rchk(PC, RDY, "pc reset");
        rchk({20'h0, pms_pkg::HARDWARE_CONFIG_REGISTER_OFS}, 32'h1 << pms_pkg::HW_READY_B, "hardware_config_register");
        rchk({20'h0, pms_pkg::BYTE_PROBE_OFS}, pms_pkg::BYTE_PROBE_VAL, "probe");
        rchk(32'h0, 32'h0, "unmapped");
        foreach (gate[i])
        begin
            wr(PC, 32'h1 << gate[i]);
            wr(PC, 32'h0);
            wr(PC, 32'h1 << gate[i]);
            rchk(PC, RDY, "one write");
            wr(PC, 32'h1 << gate[i]);
            rchk(PC, RDY | (32'h1 << gate[i]), "two writes");
            chk({mac_net_clk_en, mac_sys_clk_en, timing_clk_en, stamp_clk_en} & msk[i], ens[i] & msk[i], "en");
            wr(PC, 32'h0);
        end
        chk({led_oe_n, led_o}, 6'h04, "leds on");
        chk(hresp, 1'b0, "resp okay");
        wr(PC, 32'h1 << pms_pkg::IND_OFF_B);
        repeat (2) @(posedge hclk);
        chk(led_oe_n, 3'h1, "drain released");
        chk(led_o[2:1], 2'h3, "push idle");
        wr(PC, 32'h0);
        sleep_in(32'h1 << pms_pkg::SEL_LO);
        chk({device_ready, sys_clk_en, pll_enable, xtal_enable}, 4'h3, "d1");
        par_cs_n <= 1'b0;
        par_wr_n <= 1'b0;
        repeat (4) @(posedge hclk);
        par_cs_n <= 1'b1;
        par_wr_n <= 1'b1;
        wr(PC, AW);
        rchk(PC, RDY, "write before read");
        wr(PC, AW);
        rchk(PC, AW | RDY, "write after read");
        wr(PC, AW | SLP | (32'h2 << pms_pkg::SEL_LO));
        rchk(PC, AW | RDY, "new level with sleep");
        wr(PC, AW | SLP);
        rchk(PC, AW | RDY, "d0 sleep clears");
        // phy down before the deepest state
        phy_powered_down <= 1'b1;
        sleep_in(AW | (32'h3 << pms_pkg::SEL_LO));
        chk({xtal_enable, pll_enable, net_clk_en, device_ready}, 4'h0, "d3");
        wake_event <= 1'b1;
        repeat (20) @(posedge hclk);
        wake_event <= 1'b0;
        chk(device_ready, 1'b0, "no auto exit");
        ser_cs_n <= 1'b0;
        ser_clk <= 1'b1;
        repeat (4) @(posedge hclk);
        ser_cs_n <= 1'b1;
        ser_clk <= 1'b0;
        wait_up;
        rchk(PC, AW | RDY, "config kept");
        sleep_in(AW | (32'h2 << pms_pkg::SEL_LO));
        chk({pll_off_request, pll_enable, xtal_enable}, 3'h5, "d2");
        wake_event <= 1'b1;
        repeat (2) @(posedge hclk);
        wake_event <= 1'b0;
        wait_up;
        rchk(PC, AW | RDY, "auto wake");
        summarize();
    end
    // watchdog: the tests take a few hundred cycles, far inside the 20000-cycle limit
    initial
    begin
        #100000;
        err_count++;
        summarize();
    end
endmodule : pms_power_ctrl_tb
